/* verilog/ipei_pkg.sv */
// Register map, field layout and reset values of the input port edge interrupt block
package ipei_pkg;

   // Bus geometry
   localparam int unsigned APB_DATA_W = 32;
   localparam int unsigned APB_ADDR_W = 18;
   localparam int unsigned REG_IDX_W  = 16;
   localparam int unsigned PIN_W      = 4;
   localparam int unsigned GROUP_N    = 2;

   // Register indices; byte address is four times the index
   localparam logic [REG_IDX_W-1:0] IDX_G0_SELECT  = 16'hFF20;
   localparam logic [REG_IDX_W-1:0] IDX_G0_LEVELS  = 16'hFF21;
   localparam logic [REG_IDX_W-1:0] IDX_G0_COMPARE = 16'hFF22;
   localparam logic [REG_IDX_W-1:0] IDX_G1_SELECT  = 16'hFF24;
   localparam logic [REG_IDX_W-1:0] IDX_G1_LEVELS  = 16'hFF25;
   localparam logic [REG_IDX_W-1:0] IDX_G1_COMPARE = 16'hFF26;
   localparam logic [REG_IDX_W-1:0] IDX_G0_MASK    = 16'hFFE4;
   localparam logic [REG_IDX_W-1:0] IDX_G1_MASK    = 16'hFFE5;
   localparam logic [REG_IDX_W-1:0] IDX_G0_FLAG    = 16'hFFF4;
   localparam logic [REG_IDX_W-1:0] IDX_G1_FLAG    = 16'hFFF5;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_STATUS = 16'hFF30;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_CLEAR  = 16'hFF31;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_ENABLE = 16'hFF32;

   // Field positions
   localparam int unsigned MASK_BIT   = 0;
   localparam int unsigned FLAG_BIT   = 0;
   localparam int unsigned STATUS_G0  = 0;
   localparam int unsigned STATUS_G1  = 1;

   // Reset values
   localparam logic [PIN_W-1:0]   RST_SELECT  = 4'h0;
   localparam logic [PIN_W-1:0]   RST_COMPARE = 4'h0;
   localparam logic [GROUP_N-1:0] RST_MASK    = 2'h0;
   localparam logic [GROUP_N-1:0] RST_FLAG    = 2'h0;
   localparam logic [1:0]         RST_SYNC    = 2'h0;

endpackage : ipei_pkg

/* verilog/ipei_group.sv */
// One four-pin group: synchroniser, selected-pin match and mismatch event detector
module ipei_group
   import ipei_pkg::*;
#(
   parameter int unsigned WIDTH = PIN_W
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Pins and settings
   input  wire logic [WIDTH-1:0] pins,
   input  wire logic [WIDTH-1:0] select,
   input  wire logic [WIDTH-1:0] compare,
   // Results
   output logic      [WIDTH-1:0] level,
   output logic                  event_pulse
);

   logic [WIDTH-1:0] sync1_r;
   logic [WIDTH-1:0] sync2_r;
   logic             match;
   logic             match_prev_r;

   // Two stages; the first is read by the second only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
      end
   end

   assign level = sync2_r;

   // Unselected pins always count as matching
   assign match = &((~(sync2_r ^ compare)) | ~select);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_prev_r <= 1'b1;
      end else begin
         match_prev_r <= match;
      end
   end

   // Only a match to mismatch step fires; mismatch to mismatch stays quiet
   assign event_pulse = match_prev_r & ~match;

   chk_sync_two_stage: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn, 2) |-> (level == $past(pins, 2)))
      else $error("pin level not two cycles behind pin");

   chk_unselected_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (select == '0) && $stable(select) |-> !event_pulse)
      else $error("event with no pin selected");

   chk_event_single: assert property (@(posedge pclk) disable iff (!presetn)
      event_pulse |=> !event_pulse)
      else $error("event repeated without a return to match");

endmodule : ipei_group

/* verilog/ipei_top.sv */
// Input port edge interrupt block: APB registers, two pin groups, factor flags and interrupt
//
// Decided for this implementation: register access over APB.
module ipei_top
   import ipei_pkg::*;
#(
   parameter logic [PIN_W-1:0] COMPARE_RESET = RST_COMPARE
) (
   // APB slave
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [APB_ADDR_W-1:0] paddr,
   input  wire logic [APB_DATA_W-1:0] pwdata,
   output logic      [APB_DATA_W-1:0] prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Input pins
   input  wire logic [PIN_W-1:0]      group0_pins,
   input  wire logic [PIN_W-1:0]      group1_pins,
   // Interrupt
   output logic                       irq
);

   function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] addr,
                                    input logic [REG_IDX_W-1:0]  idx);
      reg_hit = (addr == {idx, 2'b00});
   endfunction : reg_hit

   logic [PIN_W-1:0]      select0_r;
   logic [PIN_W-1:0]      select1_r;
   logic [PIN_W-1:0]      compare0_r;
   logic [PIN_W-1:0]      compare1_r;
   logic [GROUP_N-1:0]    mask_r;
   logic [GROUP_N-1:0]    flag_r;
   logic [GROUP_N-1:0]    flag_nxt;
   logic [GROUP_N-1:0]    flag_clr;
   logic [GROUP_N-1:0]    evt;
   logic [PIN_W-1:0]      level0;
   logic [PIN_W-1:0]      level1;
   logic [APB_DATA_W-1:0] prdata_r;
   logic [APB_DATA_W-1:0] rdata_nxt;
   logic                  err_r;
   logic                  mapped;
   logic                  setup;
   logic                  wr;

   // Pin groups
   ipei_group #(.WIDTH(PIN_W)) u_group0 (
      .pclk        (pclk),
      .presetn     (presetn),
      .pins        (group0_pins),
      .select      (select0_r),
      .compare     (compare0_r),
      .level       (level0),
      .event_pulse (evt[STATUS_G0])
   );

   ipei_group #(.WIDTH(PIN_W)) u_group1 (
      .pclk        (pclk),
      .presetn     (presetn),
      .pins        (group1_pins),
      .select      (select1_r),
      .compare     (compare1_r),
      .level       (level1),
      .event_pulse (evt[STATUS_G1])
   );

   // Bus phases; zero wait states keeps the slave simple
   assign setup  = psel & ~penable;
   assign wr     = psel & penable & pwrite;
   assign pready = 1'b1;

   assign mapped = reg_hit(paddr, IDX_G0_SELECT)  | reg_hit(paddr, IDX_G0_LEVELS)  |
                   reg_hit(paddr, IDX_G0_COMPARE) | reg_hit(paddr, IDX_G1_SELECT)  |
                   reg_hit(paddr, IDX_G1_LEVELS)  | reg_hit(paddr, IDX_G1_COMPARE) |
                   reg_hit(paddr, IDX_G0_MASK)    | reg_hit(paddr, IDX_G1_MASK)    |
                   reg_hit(paddr, IDX_G0_FLAG)    | reg_hit(paddr, IDX_G1_FLAG)    |
                   reg_hit(paddr, IDX_IRQ_STATUS) | reg_hit(paddr, IDX_IRQ_CLEAR)  |
                   reg_hit(paddr, IDX_IRQ_ENABLE);

   // Selection registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         select0_r <= RST_SELECT;
         select1_r <= RST_SELECT;
      end else begin
         if (wr && reg_hit(paddr, IDX_G0_SELECT)) begin
            select0_r <= pwdata[PIN_W-1:0];
         end
         if (wr && reg_hit(paddr, IDX_G1_SELECT)) begin
            select1_r <= pwdata[PIN_W-1:0];
         end
      end
   end

   // Comparison registers; bit one means falling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare0_r <= COMPARE_RESET;
         compare1_r <= COMPARE_RESET;
      end else begin
         if (wr && reg_hit(paddr, IDX_G0_COMPARE)) begin
            compare0_r <= pwdata[PIN_W-1:0];
         end
         if (wr && reg_hit(paddr, IDX_G1_COMPARE)) begin
            compare1_r <= pwdata[PIN_W-1:0];
         end
      end
   end

   // Mask bits, reachable per group or both at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= RST_MASK;
      end else begin
         if (wr && reg_hit(paddr, IDX_G0_MASK)) begin
            mask_r[STATUS_G0] <= pwdata[MASK_BIT];
         end else if (wr && reg_hit(paddr, IDX_G1_MASK)) begin
            mask_r[STATUS_G1] <= pwdata[MASK_BIT];
         end else if (wr && reg_hit(paddr, IDX_IRQ_ENABLE)) begin
            mask_r <= pwdata[GROUP_N-1:0];
         end
      end
   end

   // Flag clear strobes from either the flag registers or the clear register
   always_comb begin
      flag_clr = '0;
      if (wr && reg_hit(paddr, IDX_G0_FLAG)) begin
         flag_clr[STATUS_G0] = pwdata[FLAG_BIT];
      end
      if (wr && reg_hit(paddr, IDX_G1_FLAG)) begin
         flag_clr[STATUS_G1] = pwdata[FLAG_BIT];
      end
      if (wr && reg_hit(paddr, IDX_IRQ_CLEAR)) begin
         flag_clr = flag_clr | pwdata[GROUP_N-1:0];
      end
   end

   // A new event wins over a clear in the same cycle, so none is lost
   assign flag_nxt = (flag_r & ~flag_clr) | evt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= RST_FLAG;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // Request gated by mask; flag is set either way
   assign irq = |(flag_r & mask_r);

   // Read mux; level registers take no write path at all
   always_comb begin
      rdata_nxt = '0;
      if (reg_hit(paddr, IDX_G0_SELECT)) begin
         rdata_nxt[PIN_W-1:0] = select0_r;
      end else if (reg_hit(paddr, IDX_G0_LEVELS)) begin
         rdata_nxt[PIN_W-1:0] = level0;
      end else if (reg_hit(paddr, IDX_G0_COMPARE)) begin
         rdata_nxt[PIN_W-1:0] = compare0_r;
      end else if (reg_hit(paddr, IDX_G1_SELECT)) begin
         rdata_nxt[PIN_W-1:0] = select1_r;
      end else if (reg_hit(paddr, IDX_G1_LEVELS)) begin
         rdata_nxt[PIN_W-1:0] = level1;
      end else if (reg_hit(paddr, IDX_G1_COMPARE)) begin
         rdata_nxt[PIN_W-1:0] = compare1_r;
      end else if (reg_hit(paddr, IDX_G0_MASK)) begin
         rdata_nxt[MASK_BIT] = mask_r[STATUS_G0];
      end else if (reg_hit(paddr, IDX_G1_MASK)) begin
         rdata_nxt[MASK_BIT] = mask_r[STATUS_G1];
      end else if (reg_hit(paddr, IDX_G0_FLAG)) begin
         rdata_nxt[FLAG_BIT] = flag_r[STATUS_G0];
      end else if (reg_hit(paddr, IDX_G1_FLAG)) begin
         rdata_nxt[FLAG_BIT] = flag_r[STATUS_G1];
      end else if (reg_hit(paddr, IDX_IRQ_STATUS)) begin
         rdata_nxt[GROUP_N-1:0] = flag_r;
      end else if (reg_hit(paddr, IDX_IRQ_ENABLE)) begin
         rdata_nxt[GROUP_N-1:0] = mask_r;
      end
   end

   // Read data and error caught in the setup cycle, held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
         err_r    <= 1'b0;
      end else if (setup) begin
         prdata_r <= pwrite ? '0 : rdata_nxt;
         err_r    <= ~mapped;
      end
   end

   assign prdata  = prdata_r;
   assign pslverr = psel & penable & err_r;

   chk_level_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && reg_hit(paddr, IDX_G1_LEVELS)
      |=> (prdata[PIN_W-1:0] == $past(level1)) && (prdata[APB_DATA_W-1:PIN_W] == '0))
      else $error("level read does not show synchronised pins");

   chk_level_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      wr && (reg_hit(paddr, IDX_G0_LEVELS) || reg_hit(paddr, IDX_G1_LEVELS))
      |=> $stable(select0_r) && $stable(select1_r) && $stable(compare0_r)
          && $stable(compare1_r) && $stable(mask_r) && !pslverr)
      else $error("write to level register changed state");

   chk_select_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && reg_hit(paddr, IDX_G0_SELECT) |=> select0_r == $past(pwdata[PIN_W-1:0]))
      else $error("select register did not take write");

   chk_compare_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && reg_hit(paddr, IDX_G1_COMPARE) |=> compare1_r == $past(pwdata[PIN_W-1:0]))
      else $error("compare register did not take write");

   chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && (reg_hit(paddr, IDX_G0_MASK) || reg_hit(paddr, IDX_G1_FLAG))
      |=> prdata[APB_DATA_W-1:1] == '0)
      else $error("unused mask or flag bits read nonzero");

   chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      evt[STATUS_G0] |=> flag_r[STATUS_G0] && (irq || !mask_r[STATUS_G0]))
      else $error("event did not set flag");

   chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
      wr && reg_hit(paddr, IDX_G0_FLAG) && pwdata[FLAG_BIT] && !evt[STATUS_G0]
      |=> !flag_r[STATUS_G0])
      else $error("write one did not clear flag");

   chk_flag_zero_write: assert property (@(posedge pclk) disable iff (!presetn)
      flag_r[STATUS_G1] && wr && reg_hit(paddr, IDX_G1_FLAG) && !pwdata[FLAG_BIT]
      |=> flag_r[STATUS_G1])
      else $error("write zero cleared flag");

   chk_masked_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (mask_r == '0) |-> !irq)
      else $error("interrupt raised while masked");

   chk_request_follows: assert property (@(posedge pclk) disable iff (!presetn)
      evt[STATUS_G1] && mask_r[STATUS_G1] && !wr |=> irq)
      else $error("enabled event raised no interrupt");

   chk_select_g1_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && reg_hit(paddr, IDX_G1_SELECT) |=> select1_r == $past(pwdata[PIN_W-1:0]))
      else $error("group one select register did not take write");

   chk_compare_g0_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && reg_hit(paddr, IDX_G0_COMPARE) |=> compare0_r == $past(pwdata[PIN_W-1:0]))
      else $error("group zero compare register did not take write");

   chk_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && reg_hit(paddr, IDX_G0_MASK) |=> mask_r[STATUS_G0] == $past(pwdata[MASK_BIT]))
      else $error("mask bit did not take write");

   chk_flag_g1_set: assert property (@(posedge pclk) disable iff (!presetn)
      evt[STATUS_G1] |=> flag_r[STATUS_G1])
      else $error("group one event did not set flag");

   chk_flag_g1_clear: assert property (@(posedge pclk) disable iff (!presetn)
      wr && reg_hit(paddr, IDX_G1_FLAG) && pwdata[FLAG_BIT] && !evt[STATUS_G1] |=> !flag_r[STATUS_G1])
      else $error("write one did not clear group one flag");

   chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      flag_r[STATUS_G0] && !(wr && (reg_hit(paddr, IDX_G0_FLAG) || reg_hit(paddr, IDX_IRQ_CLEAR)))
      |=> flag_r[STATUS_G0])
      else $error("flag dropped without a clear");

   chk_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && reg_hit(paddr, IDX_G0_FLAG)
      |=> (prdata[FLAG_BIT] == $past(flag_r[STATUS_G0])) && (prdata[APB_DATA_W-1:FLAG_BIT+1] == '0))
      else $error("flag read does not show flag");

   chk_mask_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && reg_hit(paddr, IDX_G1_MASK)
      |=> (prdata[MASK_BIT] == $past(mask_r[STATUS_G1])) && (prdata[APB_DATA_W-1:MASK_BIT+1] == '0))
      else $error("mask read does not show mask");

   chk_level_g0_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && reg_hit(paddr, IDX_G0_LEVELS)
      |=> prdata == APB_DATA_W'($past(level0)))
      else $error("group zero level read does not show pins");

   chk_status_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && reg_hit(paddr, IDX_IRQ_STATUS) |=> prdata[GROUP_N-1:0] == $past(flag_r))
      else $error("status read does not show flags");

endmodule : ipei_top

/* testbench/ipei_pin_model.sv */
// Pin driver standing in for the external switches and chips
module ipei_pin_model
   import ipei_pkg::*;
(
   // Clock
   input  wire logic             pclk,
   // Levels asked for by the bench
   input  wire logic [PIN_W-1:0] want0,
   input  wire logic [PIN_W-1:0] want1,
   // Pins
   output logic      [PIN_W-1:0] group0_pins,
   output logic      [PIN_W-1:0] group1_pins
);
   timeunit 1ns;
   timeprecision 1ns;
   // Open switches idle high, as with pull-ups fitted
   initial begin
      group0_pins = 4'hF;
      group1_pins = 4'hF;
   end
   // Levels move only just after an edge, never mid-cycle
   always @(posedge pclk) begin
      group0_pins <= want0;
      group1_pins <= want1;
   end
endmodule : ipei_pin_model

/* testbench/input_port_edge_interrupt_tb.sv */
// Self-checking bench for the input port edge interrupt block
module input_port_edge_interrupt_tb;
   import ipei_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic                  pclk = 1'b0;
   logic                  presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [APB_ADDR_W-1:0] paddr;
   logic [APB_DATA_W-1:0] pwdata, prdata, rd;
   logic [PIN_W-1:0]      want0, want1, pins0, pins1;
   int                    fail_count = 0;
   int                    total_checks = 0;
   int                    seed = 45516;
   int                    g, v, v2;
   int                    m_sel[2], m_cmp[2], m_mask[2], m_flag[2];
   int                    m_pin[2] = '{15, 15};
   bit                    m_match[2] = '{1'b1, 1'b1};
   logic [15:0]           rst_idx[8] = '{IDX_G0_SELECT, IDX_G0_COMPARE, IDX_G1_SELECT, IDX_G1_COMPARE,
                                         IDX_G0_MASK, IDX_G1_MASK, IDX_G0_FLAG, IDX_G1_FLAG};

   always #5 pclk = ~pclk;

   ipei_top ipei_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .group0_pins(pins0), .group1_pins(pins1), .irq(irq));
   ipei_pin_model ipei_pin_model_inst (.pclk(pclk), .want0(want0), .want1(want1),
      .group0_pins(pins0), .group1_pins(pins1));

   task automatic conclude;
      if (fail_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_data

   task automatic check_irq(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t irq got=%h exp=%h", $time, got, exp);
      end
   endtask : check_irq

   // One APB transfer; an idle edge after it so the next setup never lands in the same step
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fail_count++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Match state per group; only the match to mismatch step raises the flag
   function automatic void step(int k);
      bit now;
      now = ((m_pin[k] ^ m_cmp[k]) & m_sel[k]) == 0;
      if (m_match[k] && !now) m_flag[k] = 1;
      m_match[k] = now;
   endfunction : step

   task automatic wreg(input logic [15:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
      case (idx)
         IDX_G0_SELECT:  m_sel[0] = d[3:0];
         IDX_G1_SELECT:  m_sel[1] = d[3:0];
         IDX_G0_COMPARE: m_cmp[0] = d[3:0];
         IDX_G1_COMPARE: m_cmp[1] = d[3:0];
         IDX_G0_MASK:    m_mask[0] = d[0];
         IDX_G1_MASK:    m_mask[1] = d[0];
         IDX_G0_FLAG:    if (d[0]) m_flag[0] = 0;
         IDX_G1_FLAG:    if (d[0]) m_flag[1] = 0;
         IDX_IRQ_CLEAR:  m_flag = '{d[0] ? 0 : m_flag[0], d[1] ? 0 : m_flag[1]};
         IDX_IRQ_ENABLE: m_mask = '{d[0], d[1]};
         default:        ;
      endcase
      step(0);
      step(1);
   endtask : wreg

   task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      check_data(rd, exp);
   endtask : rchk

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      want0 = 4'hF;
      want1 = 4'hF;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rst_idx[i]) rchk(rst_idx[i], 32'h0);
      rchk(IDX_G0_LEVELS, 32'hF);
      wreg(IDX_G1_LEVELS, 32'h0);
      rchk(IDX_G1_LEVELS, 32'hF);
      wreg(IDX_G0_MASK, 32'hFFFFFFFF);
      rchk(IDX_G0_MASK, 32'h1);
      wreg(16'hFF40, 32'hFFFFFFFF);
      rchk(16'hFF40, 32'h0);
      check_data({31'h0, err}, 32'h1);
      wreg(IDX_IRQ_ENABLE, 32'h2);
      rchk(IDX_IRQ_ENABLE, 32'h2);
      rchk(IDX_G0_MASK, 32'h0);
      rchk(IDX_G1_MASK, 32'h1);
      // Random mix of pin moves and setting changes; flags left set half the time
      for (int i = 0; i < 80; i++) begin
         g = $random(seed) & 1;
         v = $random(seed);
         v2 = $random(seed);
         case ((v >> 4) & 3)
            0, 1: begin
               m_pin[g] = v & 15;
               if (g == 1) want1 <= v[3:0];
               else want0 <= v[3:0];
               step(g);
            end
            2: wreg(g ? IDX_G1_SELECT : IDX_G0_SELECT, v >> 8);
            default: wreg(g ? IDX_G1_COMPARE : IDX_G0_COMPARE, v >> 8);
         endcase
         wreg(g ? IDX_G1_MASK : IDX_G0_MASK, v2 >> 1);
         repeat (6) @(posedge pclk);
         rchk(g ? IDX_G1_LEVELS : IDX_G0_LEVELS, m_pin[g]);
         rchk(g ? IDX_G1_FLAG : IDX_G0_FLAG, m_flag[g]);
         check_irq(irq, 1'((m_flag[0] & m_mask[0]) | (m_flag[1] & m_mask[1])));
         rchk(IDX_IRQ_STATUS, 32'(m_flag[1] * 2 + m_flag[0]));
         wreg(g ? IDX_G1_FLAG : IDX_G0_FLAG, v2);
         rchk(g ? IDX_G1_FLAG : IDX_G0_FLAG, m_flag[g]);
      end
      wreg(IDX_IRQ_CLEAR, 32'h3);
      rchk(IDX_IRQ_STATUS, 32'h0);
      check_irq(irq, 1'b0);
      conclude();
   end

   // Whole run needs about 2100 cycles
   initial begin
      #400000;
      fail_count++;
      conclude();
   end
endmodule : input_port_edge_interrupt_tb
